// ### rtl/clb_pkg.sv
// Purpose: constants and types for the local bus interface block
// Assumes: one clock, ref_clk at 20 MHz, active-low asynchronous reset
// Notes: Function list follows
// Function
// (R1) lock output spans locked instruction and acknowledge
// (R2) lock blocks dma, refresh, external requests
// (R3) three-bit bus cycle status encoding
// (R4) hold acknowledge floats status, lock, strobes
// (R5) clock output is half rate, even duty
// (R6) pin function picks dma3 or serial pins
// (R7) third pin: int ack, timer1, serial ready
// (R8) dma requests synchronised, acknowledge per channel
// (R9) open-drain end/terminal count pin, both directions
// (R10) external winner gets floated bus and grant
// (R11) grant dropped when dma or refresh ask
// (R12) priority refresh, dma, external, cpu
// (R13) seven interrupts synchronised, edge or level, wake
// (R14) io read strobe timing, never internal
// (R15) io write strobe timing, normal dma late
// (R16) memory read strobe in T2, T3, Tw
// (R17) memory write strobe timing, normal dma late
// (R18) nmi accepted after five valid clocks
// (R19) poll input tested every five clocks
// (R20) queue status code valid one clock
// (R21) ready low inserts waits until ready
// (R22) refresh indication and nine-bit row address
// (R23) low lines carry address in T1, data later
`default_nettype none
package clb_pkg;
  typedef enum logic [2:0] {
    CLB_BS_INTA, CLB_BS_IO_READ_STROBE_N, CLB_BS_IO_WRITE_STROBE_N, CLB_BS_HALT,
    CLB_BS_FETCH, CLB_BS_MRD, CLB_BS_MWR, CLB_BS_PASSIVE
  } clb_status_t;
  typedef enum logic [1:0] {
    CLB_Q_NOP, CLB_Q_FIRST, CLB_Q_FLUSH, CLB_Q_NEXT
  } clb_queue_t;
  // pin function codes
  localparam logic [1:0] CLB_PF_DMA = 2'h0;
  localparam logic [1:0] CLB_PF_TIMER = 2'h1;
  localparam logic [1:0] CLB_PF_SERIAL = 2'h2;
  // requester kinds
  localparam logic [1:0] CLB_OWN_CPU = 2'h0;
  localparam logic [1:0] CLB_OWN_EXT = 2'h1;
  localparam logic [1:0] CLB_OWN_DMA = 2'h2;
  localparam logic [1:0] CLB_OWN_REF = 2'h3;
  localparam int CLB_NMI_CLOCKS = 5;
  localparam int CLB_POLL_CLOCKS = 5;
  localparam int CLB_NMI_VECTOR = 2;
  localparam int CLB_REF_ROW_W = 9;
  localparam int CLB_INT_N = 7;
  localparam int CLB_DMA_N = 3;
endpackage : clb_pkg
`default_nettype wire

// ### rtl/clb_arbiter.sv
// Purpose: fixed priority bus arbiter with lock and hold grant
// Assumes: requests are levels, synchronous to ref_clk
// Notes: owner changes only between bus cycles
`default_nettype none
module clb_arbiter (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic lock,
  input wire logic bus_idle,
  input wire logic ref_req,
  input wire logic dma_req,
  input wire logic hold_req_in,
  output logic [1:0] owner,
  output logic hold_grant_out
);
  typedef struct packed {
    logic [1:0] owner;
  } clb_arb_state_t;
  clb_arb_state_t st, next_st;

  always_comb begin
    next_st = st;
    // an external master keeps the bus until it drops its request
    if (bus_idle && !lock && !(st.owner == clb_pkg::CLB_OWN_EXT && hold_req_in)) begin // see (R2) (R11)
      if (ref_req) next_st.owner = clb_pkg::CLB_OWN_REF; // see (R12)
      else if (dma_req) next_st.owner = clb_pkg::CLB_OWN_DMA;
      else if (hold_req_in) next_st.owner = clb_pkg::CLB_OWN_EXT;
      else next_st.owner = clb_pkg::CLB_OWN_CPU;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) st <= '0;
    else st <= next_st;
  end

  assign owner = st.owner;
  // grant falls as soon as a higher requester appears
  assign hold_grant_out = (st.owner == clb_pkg::CLB_OWN_EXT) && !ref_req && !dma_req; // see (R10) (R11)

  a_grant_drop: assert property (@(posedge ref_clk) disable iff (!nrst)
    (owner == clb_pkg::CLB_OWN_EXT && (ref_req || dma_req)) |-> !hold_grant_out)
    else $error("grant held while dma requests"); // see (R11)
  a_lock_block: assert property (@(posedge ref_clk) disable iff (!nrst)
    (lock && owner == clb_pkg::CLB_OWN_CPU && hold_req_in) |=> owner != clb_pkg::CLB_OWN_EXT)
    else $error("external granted under lock"); // see (R2)
endmodule : clb_arbiter
`default_nettype wire

// ### rtl/clb_sync_filter.sv
// Purpose: two-stage synchroniser with per-bit rising edge output
// Assumes: inputs asynchronous
// Notes: first stage read only by second
`default_nettype none
module clb_sync_filter #(
  parameter int WIDTH = 7
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } clb_sync_state_t;
  clb_sync_state_t st, next_st;

  always_comb begin
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) st <= '0;
    else st <= next_st;
  end

  genvar gi;
  for (gi = 0; gi < WIDTH; gi++) begin : g_bit
    assign level[gi] = st.s2[gi];
    assign rise[gi] = st.s2[gi] & ~st.s3[gi];
  end
endmodule : clb_sync_filter
`default_nettype wire

// ### rtl/clb_local_bus.sv
// Purpose: local bus cycle sequencer, strobes, status, pins and arbitration
// Assumes: core requests are held until cycle_done; pins synchronous except interrupt and dma request inputs
// Notes: bus state advances on each rise of system_clock_out
`default_nettype none
module clb_local_bus (
  input wire logic ref_clk,
  input wire logic nrst,
  // core side request
  input wire logic cyc_req,
  input wire logic [2:0] cyc_kind,
  input wire logic cyc_internal,
  input wire logic cyc_lock,
  input wire logic [7:0] cyc_addr,
  input wire logic [7:0] cyc_wdata,
  output logic [7:0] cyc_rdata,
  output logic cycle_done,
  input wire logic [1:0] queue_event,
  // dma and refresh units
  input wire logic dma_req_int,
  input wire logic dma_write,
  input wire logic dma_extended,
  input wire logic [1:0] dma_channel,
  input wire logic dma_tc,
  output logic dma_end,
  input wire logic ref_req,
  input wire logic [8:0] ref_row,
  // other units
  input wire logic [1:0] pin_function_select,
  input wire logic serial_tx,
  output logic serial_rx,
  input wire logic timer1_output,
  input wire logic serial_can_take,
  input wire logic poll_active,
  output logic poll_release,
  output logic [6:0] int_pending,
  input wire logic [6:0] int_edge_mode,
  output logic nmi_accept,
  output logic wake,
  // pins
  output logic system_clock_out,
  output logic [2:0] bus_cycle_status,
  output logic bus_lock_n,
  output logic ctrl_oe,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic mem_read_strobe_n,
  output logic mem_write_strobe_n,
  output logic refresh_cycle_n,
  output logic [8:0] addr_low_out,
  input wire logic [7:0] addr_data_low_in,
  output logic [7:0] addr_data_low_out,
  output logic addr_data_low_oe,
  output logic [1:0] queue_state_out,
  input wire logic ready_in,
  input wire logic poll_n,
  input wire logic nmi_in,
  input wire logic [6:0] external_int_inputs,
  input wire logic [2:0] dma_req_in,
  output logic [2:0] dma_grant_n,
  input wire logic dma_ch3_req_in,
  output logic dma_ch3_grant_n,
  output logic int_ack_out_n,
  input wire logic transfer_stop_terminal_n_in,
  output logic transfer_stop_terminal_n_out,
  output logic transfer_stop_terminal_n_oe,
  input wire logic hold_req_in,
  output logic hold_grant_out
);
  typedef enum {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4} clb_tstate_t;
  typedef struct packed {
    logic clk_div;
    clb_tstate_t t;
    logic [2:0] kind;
    logic [1:0] who;
    logic internal;
    logic ext;
    logic dwrite;
    logic [1:0] chan;
    logic waited;
    logic locked;
    logic [7:0] rdata;
    logic [1:0] qs;
    logic [2:0] nmi_cnt;
    logic nmi_done;
    logic [2:0] poll_cnt;
    logic poll_hit;
    logic [6:0] pend;
  } clb_state_t;
  clb_state_t st, next_st;

  logic [1:0] owner;
  logic [6:0] int_lvl, int_rise;
  logic [3:0] dreq_lvl;
  logic tick;
  logic bus_idle;
  logic arb_slot;
  logic floated;
  logic lock;
  logic dma_any;
  logic in_strobe;
  logic is_dma;

  // --------------------------------------------------------------------
  // synchronisers
  // --------------------------------------------------------------------
  clb_sync_filter #(.WIDTH(clb_pkg::CLB_INT_N)) u_int_sync (
    .ref_clk(ref_clk), .nrst(nrst), .din(external_int_inputs), .level(int_lvl), .rise(int_rise)); // see (R13)
  clb_sync_filter #(.WIDTH(4)) u_dma_sync (
    .ref_clk(ref_clk), .nrst(nrst),
    .din({pin_function_select == clb_pkg::CLB_PF_DMA && dma_ch3_req_in, dma_req_in}),
    .level(dreq_lvl), .rise()); // see (R6) (R8)

  assign dma_any = dma_req_int | (|dreq_lvl);
  assign lock = !bus_lock_n;

  clb_arbiter u_arb (
    .ref_clk(ref_clk), .nrst(nrst), .lock(lock), .bus_idle(arb_slot),
    .ref_req(ref_req), .dma_req(dma_any), .hold_req_in(hold_req_in),
    .owner(owner), .hold_grant_out(hold_grant_out));

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  assign tick = !st.clk_div;  // next ref edge is a rising output edge
  assign bus_idle = (st.t == ST_IDLE);
  // owner moves only on edges where no cycle can start
  assign arb_slot = bus_idle && !tick;
  assign floated = (owner == clb_pkg::CLB_OWN_EXT);
  assign is_dma = (st.who == clb_pkg::CLB_OWN_DMA);

  always_comb begin
    next_st = st;
    next_st.clk_div = !st.clk_div; // see (R5)
    next_st.qs = clb_pkg::CLB_Q_NOP;
    if (tick) begin
      next_st.qs = queue_event; // see (R20)
      case (st.t)
        ST_IDLE: begin
          if (!(cyc_req && cyc_lock)) next_st.locked = 1'b0; // see (R1)
          if (owner == clb_pkg::CLB_OWN_REF && ref_req) begin
            next_st.t = ST_T1;
            next_st.kind = clb_pkg::CLB_BS_MRD; // see (R3)
            next_st.who = owner;
            next_st.internal = 1'b0;
          end else if (owner == clb_pkg::CLB_OWN_DMA && dma_any) begin
            next_st.t = ST_T1;
            next_st.kind = dma_write ? clb_pkg::CLB_BS_MWR : clb_pkg::CLB_BS_MRD;
            next_st.who = owner;
            next_st.dwrite = dma_write;
            next_st.ext = dma_extended;
            next_st.chan = dma_channel;
            next_st.internal = 1'b0;
          end else if (owner == clb_pkg::CLB_OWN_CPU && cyc_req) begin
            next_st.t = ST_T1;
            next_st.kind = cyc_kind;
            next_st.who = owner;
            next_st.internal = cyc_internal;
            next_st.locked = cyc_lock || cyc_kind == clb_pkg::CLB_BS_INTA; // see (R1)
          end
        end
        ST_T1: next_st.t = ST_T2;
        ST_T2: next_st.t = ready_in ? ST_T3 : ST_TW; // see (R21)
        ST_T3: next_st.t = ST_T4;
        ST_TW: begin
          if (ready_in) next_st.t = ST_T4; // see (R21)
        end
        ST_T4: begin
          next_st.t = ST_IDLE;
          next_st.rdata = addr_data_low_in;
          if (!(cyc_req && cyc_lock)) next_st.locked = 1'b0;
        end
        default: next_st.t = ST_IDLE;
      endcase
    end
    // nmi counted once per output clock, accepted once per high period
    if (nmi_in) begin
      if (tick && st.nmi_cnt != 3'(clb_pkg::CLB_NMI_CLOCKS)) next_st.nmi_cnt = st.nmi_cnt + 3'h1;
    end else begin
      next_st.nmi_cnt = '0;
      next_st.nmi_done = 1'b0;
    end
    if (nmi_accept) next_st.nmi_done = 1'b1; // see (R18)
    // poll sampled every fifth clock
    next_st.poll_hit = 1'b0;
    if (poll_active) begin
      next_st.poll_cnt = (st.poll_cnt == 3'(clb_pkg::CLB_POLL_CLOCKS - 1)) ? 3'h0 : st.poll_cnt + 3'h1;
      if (st.poll_cnt == 3'(clb_pkg::CLB_POLL_CLOCKS - 1) && !poll_n) next_st.poll_hit = 1'b1; // see (R19)
    end else begin
      next_st.poll_cnt = '0;
    end
    // interrupts: edge or level per input; set wins over acknowledge clear
    for (int i = 0; i < clb_pkg::CLB_INT_N; i++) begin
      if (tick && st.t == ST_T4 && st.kind == clb_pkg::CLB_BS_INTA && i == 0) next_st.pend[i] = 1'b0;
      if (int_edge_mode[i] ? int_rise[i] : int_lvl[i]) next_st.pend[i] = 1'b1; // see (R13)
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) st <= '{t: ST_IDLE, kind: clb_pkg::CLB_BS_PASSIVE, default: '0};
    else st <= next_st;
  end

  // --------------------------------------------------------------------
  // pin outputs
  // --------------------------------------------------------------------
  assign in_strobe = (st.t == ST_T2) || (st.t == ST_T3) || (st.t == ST_TW);
  assign system_clock_out = st.clk_div;
  assign bus_cycle_status = bus_idle ? clb_pkg::CLB_BS_PASSIVE : st.kind; // see (R3)
  assign bus_lock_n = !st.locked; // see (R1)
  assign ctrl_oe = !floated; // see (R4) (R10)
  assign io_read_strobe_n = !(in_strobe && !st.internal && // see (R14)
    ((st.kind == clb_pkg::CLB_BS_IO_READ_STROBE_N && !is_dma) || (is_dma && st.dwrite)));
  assign io_write_strobe_n = !(!st.internal && // see (R15)
    ((in_strobe && st.kind == clb_pkg::CLB_BS_IO_WRITE_STROBE_N && !is_dma) ||
     (is_dma && !st.dwrite && (st.ext ? in_strobe : st.t == ST_T3 || st.t == ST_TW))));
  assign mem_read_strobe_n = !(in_strobe && !st.internal && // see (R16)
    (st.kind == clb_pkg::CLB_BS_MRD || st.kind == clb_pkg::CLB_BS_FETCH));
  assign mem_write_strobe_n = !(st.kind == clb_pkg::CLB_BS_MWR && !st.internal && // see (R17)
    ((is_dma && !st.ext) ? (st.t == ST_T3 || st.t == ST_TW) : in_strobe));
  assign refresh_cycle_n = !(!bus_idle && st.who == clb_pkg::CLB_OWN_REF); // see (R22)
  assign addr_low_out = (st.who == clb_pkg::CLB_OWN_REF) ? ref_row : {1'b0, cyc_addr}; // see (R22)
  assign addr_data_low_out = (st.t == ST_T1) ? cyc_addr : cyc_wdata; // see (R23)
  assign addr_data_low_oe = !floated && !st.internal && (st.t == ST_T1 ||
    (!bus_idle && (st.kind == clb_pkg::CLB_BS_MWR || st.kind == clb_pkg::CLB_BS_IO_WRITE_STROBE_N))); // see (R23)
  assign cyc_rdata = st.rdata;
  assign cycle_done = tick && st.t == ST_T4 && st.who == clb_pkg::CLB_OWN_CPU;
  assign queue_state_out = st.qs; // see (R20)
  assign poll_release = st.poll_hit;
  assign nmi_accept = tick && nmi_in && st.nmi_cnt == 3'(clb_pkg::CLB_NMI_CLOCKS - 1) && !st.nmi_done;
  assign int_pending = st.pend;
  assign wake = nmi_accept || (|st.pend); // see (R13) (R18)
  genvar gc;
  for (gc = 0; gc < clb_pkg::CLB_DMA_N; gc++) begin : g_ack
    assign dma_grant_n[gc] = !(is_dma && !bus_idle && st.chan == 2'(gc)); // see (R8)
  end
  assign dma_ch3_grant_n = (pin_function_select == clb_pkg::CLB_PF_DMA) ? // see (R6)
    !(is_dma && !bus_idle && st.chan == 2'h3) : serial_tx;
  assign serial_rx = dma_ch3_req_in;
  always_comb begin
    case (pin_function_select) // see (R7)
      clb_pkg::CLB_PF_DMA: int_ack_out_n = !(in_strobe && st.kind == clb_pkg::CLB_BS_INTA);
      clb_pkg::CLB_PF_TIMER: int_ack_out_n = timer1_output;
      default: int_ack_out_n = !serial_can_take;
    endcase
  end
  assign transfer_stop_terminal_n_out = 1'b0;
  assign transfer_stop_terminal_n_oe = dma_tc; // see (R9)
  assign dma_end = is_dma && !bus_idle && !transfer_stop_terminal_n_in && !dma_tc; // see (R9)

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  sequence s_wait_entry;
    st.t == ST_T2 && tick && !ready_in;
  endsequence
  a_ready_wait: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_wait_entry |=> st.t == ST_TW) else $error("no wait after ready low"); // see (R21)
  a_clk_half: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) |-> system_clock_out != $past(system_clock_out)) else $error("clock out not half rate"); // see (R5)
  a_nmi_five: assert property (@(posedge ref_clk) disable iff (!nrst)
    nmi_accept |-> $past(nmi_in, 8)) else $error("nmi accepted early"); // see (R18)
  a_qs_one: assert property (@(posedge ref_clk) disable iff (!nrst)
    (queue_state_out != clb_pkg::CLB_Q_NOP) |=> queue_state_out == clb_pkg::CLB_Q_NOP)
    else $error("queue code held too long"); // see (R20)
  a_ior_internal: assert property (@(posedge ref_clk) disable iff (!nrst)
    st.internal |-> io_read_strobe_n && io_write_strobe_n) else $error("io strobe internal"); // see (R14)
  a_mwr_late: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st.t == ST_T2 && is_dma && !st.ext) |-> mem_write_strobe_n) else $error("normal dma write early"); // see (R17)
  a_refresh_ind: assert property (@(posedge ref_clk) disable iff (!nrst)
    !refresh_cycle_n |-> !mem_read_strobe_n || !in_strobe) else $error("refresh without read"); // see (R22)
  a_float_ctl: assert property (@(posedge ref_clk) disable iff (!nrst)
    hold_grant_out |-> !ctrl_oe) else $error("control driven in hold"); // see (R4)
  sequence s_wait_exit;
    st.t == ST_TW && tick && ready_in;
  endsequence
  a_wait_leave: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_wait_exit |=> st.t == ST_T4) else $error("no t4 after ready high"); // see (R21)
  a_float_data: assert property (@(posedge ref_clk) disable iff (!nrst)
    hold_grant_out |-> !addr_data_low_oe) else $error("data driven in hold"); // see (R10)
  a_iow_late: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st.t == ST_T2 && is_dma && !st.ext && !st.dwrite) |-> io_write_strobe_n)
    else $error("normal dma read io write early"); // see (R15)
  a_ack_t1: assert property (@(posedge ref_clk) disable iff (!nrst)
    (pin_function_select == clb_pkg::CLB_PF_DMA && st.t == ST_T1) |-> int_ack_out_n)
    else $error("acknowledge out in t1"); // see (R7)
endmodule : clb_local_bus
`default_nettype wire

// ### verif/clb_bus_partner.sv
// Purpose: external memory and io device model on the local bus
// Assumes: strobes active low, slow mode chosen by the bench
// Notes: released data lines show the inverse of their last value
`default_nettype none
module clb_bus_partner (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic [2:0] bus_cycle_status,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe,
  output logic [7:0] ad_in,
  output logic ready_in,
  output logic [7:0] last_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] addr = 8'h00;
  logic [7:0] held = 8'h00;
  logic strobe_q = 1'b0;
  int hold_left = 0;
  int wait_left = 0;
  // data answered under the read strobe and one t-state after it
  assign ad_in = (hold_left > 0) ? held : ~held;
  // slow device keeps ready low for six ref clocks from strobe start
  assign ready_in = (wait_left == 0);
  always @(posedge ref_clk) begin
    if (ad_oe && rd_n && wr_n && bus_cycle_status != 3'h7) addr <= ad_out;
    if (!wr_n) last_wdata <= ad_out;
    if (!rd_n) begin
      held <= addr ^ 8'hA5;
      hold_left <= 2;
    end else if (hold_left > 0) hold_left <= hold_left - 1;
    strobe_q <= !(rd_n && wr_n);
    if (!(rd_n && wr_n) && !strobe_q) wait_left <= slow ? 6 : 0;
    else if (wait_left > 0) wait_left <= wait_left - 1;
  end
endmodule : clb_bus_partner
`default_nettype wire

// ### verif/tb.sv
// Purpose: self-checking bench for the local bus block
// Assumes: partner model answers memory and io cycles
// Notes: end/terminal pin resolved here with a pull-up
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, nrst, cyc_req, cyc_internal, cyc_lock, cycle_done, dma_req_int, dma_write, dma_extended;
  logic dma_tc, dma_end, ref_req, serial_tx, serial_rx, timer1_output, serial_can_take, poll_active;
  logic poll_release, nmi_accept, wake, system_clock_out, bus_lock_n, ctrl_oe, io_read_strobe_n;
  logic io_write_strobe_n, mem_read_strobe_n, mem_write_strobe_n, refresh_cycle_n, addr_data_low_oe;
  logic ready_in, poll_n, nmi_in, dma_ch3_req_in, dma_ch3_grant_n, int_ack_out_n, hold_req_in, hold_grant_out;
  logic transfer_stop_terminal_n_in, transfer_stop_terminal_n_out, transfer_stop_terminal_n_oe, end_n, slow;
  logic [2:0] cyc_kind, bus_cycle_status, dma_req_in, dma_grant_n, st_first;
  logic [7:0] cyc_addr, cyc_wdata, cyc_rdata, addr_data_low_in, addr_data_low_out, last_wdata;
  logic [1:0] queue_event, dma_channel, pin_function_select, queue_state_out;
  logic [8:0] ref_row, addr_low_out, row_seen;
  logic [6:0] int_pending, int_edge_mode, external_int_inputs;
  logic st_got;
  logic [1:0] qs_seen;
  int fails = 0;
  int cmp_count = 0;
  int n_mrd, n_mwr, n_io_read_strobe_n, n_io_write_strobe_n, n_ack, n_lock, n_grant, n_dack, n_tc, n_end, n_nmi, n_poll, n_qs;
  // open-drain pin with pull-up
  assign transfer_stop_terminal_n_in = transfer_stop_terminal_n_oe ? transfer_stop_terminal_n_out : end_n;
  clb_local_bus i_dut (.*);
  clb_bus_partner i_mem (.ref_clk(ref_clk), .slow(slow), .bus_cycle_status(bus_cycle_status),
    .rd_n(mem_read_strobe_n & io_read_strobe_n), .wr_n(mem_write_strobe_n & io_write_strobe_n),
    .ad_out(addr_data_low_out), .ad_oe(addr_data_low_oe), .ad_in(addr_data_low_in),
    .ready_in(ready_in), .last_wdata(last_wdata));
  always #25 ref_clk = ~ref_clk;
  // -------------------------------------------------
  // pin monitor
  // -------------------------------------------------
  always @(posedge ref_clk) begin
    n_mrd += !mem_read_strobe_n;
    n_mwr += !mem_write_strobe_n;
    n_io_read_strobe_n += !io_read_strobe_n;
    n_io_write_strobe_n += !io_write_strobe_n;
    n_ack += !int_ack_out_n;
    n_lock += !bus_lock_n;
    n_grant += hold_grant_out;
    n_dack += (dma_grant_n !== 3'h7);
    n_tc += !transfer_stop_terminal_n_in;
    n_end += dma_end;
    n_nmi += nmi_accept;
    n_poll += poll_release;
    n_qs += (queue_state_out != 2'h0);
    if (queue_state_out != 2'h0) qs_seen = queue_state_out;
    if (!st_got && bus_cycle_status !== 3'h7) begin
      st_first = bus_cycle_status;
      st_got = 1'b1;
    end
    if (!refresh_cycle_n) row_seen = addr_low_out;
  end
  task automatic clr;
    {n_mrd, n_mwr, n_io_read_strobe_n, n_io_write_strobe_n, n_ack, n_lock, n_grant, n_dack, n_tc, n_end, n_nmi, n_poll, n_qs} = '0;
    st_got = 1'b0;
  endtask : clr
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : clk
  task automatic cpu(input logic [2:0] k, input logic in, input logic lk, input logic [7:0] a, output int len);
    clr();
    @(posedge ref_clk);
    cyc_req <= 1'b1; cyc_kind <= k; cyc_internal <= in; cyc_lock <= lk; cyc_addr <= a; cyc_wdata <= ~a;
    for (len = 0; len < 200; len++) begin
      @(posedge ref_clk);
      if (cycle_done === 1'b1) break;
    end
    cyc_req <= 1'b0;
    cyc_lock <= 1'b0;
    if (len == 200) fails++;
    #1;
  endtask : cpu
  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task automatic t_idle;
    logic prev;
    `CHK(bus_cycle_status, 3'h7)
    `CHK({mem_read_strobe_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n}, 4'hF)
    `CHK(ctrl_oe, 1'b1)
    for (int i = 0; i < 6; i++) begin
      prev = system_clock_out;
      clk(1);
      `CHK(system_clock_out, ~prev)
    end
  endtask : t_idle
  task automatic t_kinds;
    int len;
    for (int k = 0; k < 7; k++) begin
      cpu(k[2:0], 1'b0, 1'b0, 8'h30 + k[7:0], len);
      `CHK(st_first, k[2:0])
      `CHK(n_mrd, (k == 4 || k == 5) ? 4 : 0)
      `CHK(n_mwr, (k == 6) ? 4 : 0)
      `CHK(n_io_read_strobe_n, (k == 1) ? 4 : 0)
      `CHK(n_io_write_strobe_n, (k == 2) ? 4 : 0)
      `CHK(n_ack, (k == 0) ? 4 : 0)
      `CHK(n_lock > 0, k == 0)
      if (k == 1 || k == 4 || k == 5) `CHK(cyc_rdata, (8'h30 + k[7:0]) ^ 8'hA5)
      if (k == 2 || k == 6) `CHK(last_wdata, ~(8'h30 + k[7:0]))
    end
    cpu(3'h1, 1'b1, 1'b0, 8'h11, len);
    `CHK(n_io_read_strobe_n, 0)
    cpu(3'h2, 1'b1, 1'b0, 8'h12, len);
    `CHK(n_io_write_strobe_n, 0)
  endtask : t_kinds
  task automatic t_wait;
    int l0, l1;
    cpu(3'h5, 1'b0, 1'b0, 8'h5C, l0);
    slow = 1'b1;
    cpu(3'h5, 1'b0, 1'b0, 8'h5D, l1);
    slow = 1'b0;
    `CHK(l1 >= l0 + 4, 1'b1)
    `CHK(n_mrd >= 8, 1'b1)
    `CHK(cyc_rdata, 8'h5D ^ 8'hA5)
  endtask : t_wait
  task automatic t_hold;
    int len;
    fork
      cpu(3'h4, 1'b0, 1'b1, 8'h40, len);
      begin clk(3); hold_req_in <= 1'b1; end
    join
    `CHK(n_grant, 0)
    `CHK(n_lock > 0, 1'b1)
    for (int i = 0; i < 40 && hold_grant_out !== 1'b1; i++) clk(1);
    `CHK(hold_grant_out, 1'b1)
    `CHK(ctrl_oe, 1'b0)
    `CHK(addr_data_low_oe, 1'b0)
    ref_req <= 1'b1;
    ref_row <= 9'h1A5;
    for (int i = 0; i < 40 && hold_grant_out !== 1'b0; i++) clk(1);
    `CHK(hold_grant_out, 1'b0)
    hold_req_in <= 1'b0;
    clr();
    for (int i = 0; i < 60 && refresh_cycle_n !== 1'b0; i++) clk(1);
    ref_req <= 1'b0;
    clk(16);
    `CHK(row_seen, 9'h1A5)
    `CHK(st_first, 3'h5)
    `CHK(n_mrd, 4)
  endtask : t_hold
  task automatic t_dma;
    for (int c = 0; c < 3; c++) begin
      clr();
      @(posedge ref_clk);
      dma_write <= (c == 0); dma_extended <= (c == 1); dma_channel <= c[1:0]; dma_tc <= (c == 1);
      end_n <= (c != 2); dma_req_int <= (c != 2); dma_req_in <= {c == 2, 2'b00};
      for (int i = 0; i < 40 && bus_cycle_status === 3'h7; i++) @(posedge ref_clk);
      dma_req_int <= 1'b0; dma_req_in <= 3'h0;
      clk(16);
      dma_tc <= 1'b0; end_n <= 1'b1;
      `CHK(n_mwr, (c == 0) ? 2 : 0)
      `CHK(n_io_read_strobe_n, (c == 0) ? 4 : 0)
      `CHK(n_io_write_strobe_n, (c == 1) ? 4 : (c == 2) ? 2 : 0)
      `CHK(n_dack > 0, 1'b1)
      if (c == 1) `CHK(n_tc > 0, 1'b1)
      if (c == 2) `CHK(n_end > 0, 1'b1)
    end
  endtask : t_dma
  task automatic t_pins;
    for (int v = 0; v < 2; v++) begin
      pin_function_select <= 2'h2; dma_ch3_req_in <= v[0]; serial_tx <= v[0]; serial_can_take <= v[0];
      clk(4);
      `CHK(serial_rx, v[0])
      `CHK(dma_ch3_grant_n, v[0])
      `CHK(int_ack_out_n, ~v[0])
      pin_function_select <= 2'h1; timer1_output <= v[0];
      clk(4);
      `CHK(int_ack_out_n, v[0])
    end
    pin_function_select <= 2'h0;
    external_int_inputs <= 7'h04;
    clk(6);
    `CHK(int_pending[2], 1'b1)
    `CHK(wake, 1'b1)
    external_int_inputs <= 7'h00;
  endtask : t_pins
  task automatic t_nmi_poll;
    clr();
    nmi_in <= 1'b1; clk(3); nmi_in <= 1'b0; clk(6);
    `CHK(n_nmi, 0)
    nmi_in <= 1'b1; clk(12); nmi_in <= 1'b0; clk(2);
    `CHK(n_nmi, 1)
    poll_active <= 1'b1; clk(12);
    `CHK(n_poll, 0)
    poll_n <= 1'b0; clk(10);
    `CHK(n_poll > 0, 1'b1)
    poll_active <= 1'b0; poll_n <= 1'b1;
    queue_event <= 2'h3; clk(2); queue_event <= 2'h0; clk(4);
    `CHK(n_qs, 1)
    `CHK(qs_seen, 2'h3)
  endtask : t_nmi_poll
  // -------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------
  initial begin
    ref_clk = 0; nrst = 0; slow = 0; end_n = 1; clr();
    {cyc_req, cyc_internal, cyc_lock, dma_req_int, dma_write, dma_extended, dma_tc, ref_req} = '0;
    {serial_tx, timer1_output, serial_can_take, poll_active, nmi_in, dma_ch3_req_in, hold_req_in} = '0;
    poll_n = 1; cyc_kind = 3'h7; cyc_addr = 8'h00; cyc_wdata = 8'h00; queue_event = 2'h0;
    dma_channel = 2'h0; pin_function_select = 2'h0; ref_row = 9'h000; dma_req_in = 3'h0;
    int_edge_mode = 7'h00; external_int_inputs = 7'h00;
    clk(2);
    nrst <= 1'b1;
    clk(1);
    t_idle(); t_kinds(); t_wait(); t_hold(); t_dma(); t_pins(); t_nmi_poll();
    finish_test();
  end
  initial begin
    #1000000;
    fails++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
